// [inc/touch_sar_pkg.sv]
/*
  Shared constants for the touch-panel converter sequencer: register indices,
  field positions, reset values, timing counts and the measurement enumeration.
  Assumes a 20 MHz register clock; byte address of a register is four times its index.
*/
package touch_sar_pkg;
  // Register indices; byte address is index times four.
  localparam logic [7:0] CONV_POWER_IDX = 8'h02;
  localparam logic [7:0] MODE_IDX       = 8'h03;
  localparam logic [7:0] STAB_IDX       = 8'h04;
  localparam logic [7:0] INTERVAL_IDX   = 8'h05;
  localparam logic [7:0] STATUS_IDX     = 8'h06;
  localparam logic [7:0] RESULT_IDX     = 8'h08;
  localparam logic [7:0] RESULT_END_IDX = 8'h0f;

  // Field positions.
  localparam int PWR_DOWN_BIT  = 7;
  localparam int RES_LSB       = 5;
  localparam int MODE_SELF_BIT = 7;
  localparam int SCAN_LSB      = 2;
  localparam int IRQ_LSB       = 0;

  // Reset values.
  localparam logic [7:0]  CONV_POWER_RST = 8'h00;
  localparam logic [7:0]  MODE_RST       = 8'h00;
  localparam logic [7:0]  STAB_RST       = 8'h0a;
  localparam logic [15:0] INTERVAL_RST   = 16'h0064;

  // Resolution and interrupt-function codes.
  localparam logic [1:0] RES_12 = 2'h0;
  localparam logic [1:0] RES_8  = 2'h1;
  localparam logic [1:0] RES_10 = 2'h2;
  localparam logic [1:0] IRQ_PEN      = 2'h0;
  localparam logic [1:0] IRQ_DATA     = 2'h1;
  localparam logic [1:0] IRQ_PEN_DATA = 2'h2;

  // Settling and interval counters run on a 1 us tick.
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_TIME_NS  = 1000;
  localparam logic [4:0] TICK_CYC = 5'(TICK_TIME_NS / CLK_PERIOD_NS);

  // Number of measurements; a search result equal to it means none left.
  localparam logic [2:0] MEAS_NONE = 3'h4;

  typedef enum logic [1:0] {MEAS_Y, MEAS_X, MEAS_Z1, MEAS_Z2} meas_t;
  typedef enum logic [2:0] {S_IDLE, S_HOST_WAIT, S_SETTLE, S_CONVERT, S_INTERVAL} seq_state_t;
endpackage

// [rtl/touch_panel_sar_sequencer.sv]
/*
  Touch-panel sequencer: APB register slave, panel driver and converter control.
  Assumes a converter that takes a one-cycle start pulse and answers with done and
  right-justified data, and a touch detector already synchronous to pclk.
*/
`timescale 1ns/100ps

// Operation
// - Y reading senses X-plus with Y drivers on and digitizes it.
// - After Y, drive the other axis and convert the X position.
// - Wait a settling interval between driver turn-on and sampling.
// - Settling interval is the programmable stabilization delay.
// - Self-run mode starts conversions on touch using the scan field.
// - After a set, wait the interval, recheck touch, repeat if touched.
// - Host-run raises pen interrupt on touch and waits for scan-field write.
// - Host-run stops when recheck finds no touch; next touch re-interrupts.
// - Two cross-panel pressure readings are available besides X and Y.
// - An input selector feeds one shared converter from all sources.
// - A completed result goes to the register of its quantity.
// - Power-down bit forces the converter off regardless of activity.
// - Mode register bits seven to zero set the operating mode.
// - One pin supplies drive voltage, a companion pin supplies ground.
// - Panel conversions use differential input and plate reference.
// - Mode register top bit picks self-run or host-run control.
// - Resolution of 8, 10 or 12 bits from config bits six to five.
// - Each result reads as two unsigned 8-bit registers.
module touch_panel_sar_sequencer (
  // Clock, reset and enable.
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Panel side.
  input  wire logic        touch,
  output logic             drive_xp,
  output logic             drive_xn,
  output logic             drive_yp,
  output logic             drive_yn,
  output logic             ref_diff,
  // Converter side.
  output logic      [1:0]  conv_channel,
  output logic      [1:0]  conv_resolution,
  output logic             conv_start,
  output logic             conv_powerdown,
  input  wire logic        conv_done,
  input  wire logic [11:0] conv_data,
  // Interrupt, active low.
  output logic             interrupt_pin_a_n
);

  logic [7:0]                      conv_power_config;
  logic [7:0]                      converter_mode_control;
  logic [7:0]                      stab_delay;
  logic [15:0]                     interval_period;
  logic [11:0]                     result [4];
  touch_sar_pkg::seq_state_t       state;
  touch_sar_pkg::meas_t            meas;
  logic [4:0]                      tick_cnt;
  logic                            tick;
  logic [15:0]                     wait_cnt;
  logic                            pen_pending;
  logic                            data_avail;
  logic [7:0]                      idx;
  logic                            wr_en;
  logic                            rd_en;
  logic                            mapped;
  logic [31:0]                     rd_word;
  logic                            pwr_down;
  logic                            self_run;
  logic [3:0]                      scan;
  logic [1:0]                      irq_func;
  logic [2:0]                      first_meas;
  logic [2:0]                      host_first;
  logic [2:0]                      after_meas;
  logic [11:0]                     masked;
  logic [15:0]                     settle_load;

  // Finds the first selected measurement at or after a position, Y-X-Z1-Z2 order.
  function automatic logic [2:0] next_meas(input logic [3:0] sel, input logic [2:0] from);
    logic [2:0] found;
    found = touch_sar_pkg::MEAS_NONE;
    for (int i = 3; i >= 0; i--) begin
      if (sel[i] && (3'(i) >= from)) begin
        found = 3'(i);
      end
    end
    return found;
  endfunction

  // Masks converter data to the programmed resolution.
  function automatic logic [11:0] res_mask(input logic [1:0] res, input logic [11:0] d);
    logic [11:0] m;
    m = d;
    if (res == touch_sar_pkg::RES_8) begin
      m = {4'h0, d[7:0]};
    end else if (res == touch_sar_pkg::RES_10) begin
      m = {2'h0, d[9:0]};
    end
    return m;
  endfunction

  // Field decode of the configuration registers.
  assign pwr_down   = conv_power_config[touch_sar_pkg::PWR_DOWN_BIT];
  assign self_run   = converter_mode_control[touch_sar_pkg::MODE_SELF_BIT];
  assign scan       = converter_mode_control[touch_sar_pkg::SCAN_LSB +: 4];
  assign irq_func   = converter_mode_control[touch_sar_pkg::IRQ_LSB +: 2];
  assign idx        = paddr[9:2];
  assign wr_en      = ce && psel && penable && pready && pwrite;
  assign rd_en      = ce && psel && penable && pready && !pwrite;
  assign first_meas = next_meas(scan, 3'h0);
  assign host_first = next_meas(pwdata[touch_sar_pkg::SCAN_LSB +: 4], 3'h0);
  assign masked     = res_mask(conv_power_config[touch_sar_pkg::RES_LSB +: 2], conv_data);
  // One extra tick so a free-running tick never shortens the programmed settling time.
  assign settle_load = 16'({8'h00, stab_delay} + 16'h0001);

  // Next measurement after the current one; X is dropped once the touch is gone.
  always_comb begin
    after_meas = next_meas(scan, 3'({1'b0, meas} + 3'h1));
    if (after_meas == 3'(touch_sar_pkg::MEAS_X) && !touch) begin
      after_meas = next_meas(scan, 3'h2);
    end
  end

  // Read multiplexer; results appear as high and low bytes.
  always_comb begin
    rd_word = 32'h0000_0000;
    mapped  = 1'b1;
    if (idx == touch_sar_pkg::CONV_POWER_IDX) begin
      rd_word = {24'h00_0000, conv_power_config};
    end else if (idx == touch_sar_pkg::MODE_IDX) begin
      rd_word = {24'h00_0000, converter_mode_control};
    end else if (idx == touch_sar_pkg::STAB_IDX) begin
      rd_word = {24'h00_0000, stab_delay};
    end else if (idx == touch_sar_pkg::INTERVAL_IDX) begin
      rd_word = {16'h0000, interval_period};
    end else if (idx == touch_sar_pkg::STATUS_IDX) begin
      rd_word = {28'h000_0000, touch, data_avail, pen_pending, (state != touch_sar_pkg::S_IDLE)};
    end else if (idx >= touch_sar_pkg::RESULT_IDX && idx <= touch_sar_pkg::RESULT_END_IDX) begin
      if (idx[0]) begin
        rd_word = {24'h00_0000, result[idx[2:1]][7:0]};
      end else begin
        rd_word = {28'h000_0000, result[idx[2:1]][11:8]};
      end
    end else begin
      mapped = 1'b0;
    end
  end

  // APB answer: ready in the first access cycle, data and error with it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready  <= psel && !penable;
      prdata  <= (psel && !penable && !pwrite) ? rd_word : 32'h0000_0000;
      pslverr <= psel && !penable && !mapped;
    end
  end

  // Software-written registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_power_config      <= touch_sar_pkg::CONV_POWER_RST;
      converter_mode_control <= touch_sar_pkg::MODE_RST;
      stab_delay             <= touch_sar_pkg::STAB_RST;
      interval_period        <= touch_sar_pkg::INTERVAL_RST;
    end else if (wr_en) begin
      if (idx == touch_sar_pkg::CONV_POWER_IDX) begin
        conv_power_config <= pwdata[7:0];
      end
      if (idx == touch_sar_pkg::MODE_IDX) begin
        converter_mode_control <= pwdata[7:0];
      end
      if (idx == touch_sar_pkg::STAB_IDX) begin
        stab_delay <= pwdata[7:0];
      end
      if (idx == touch_sar_pkg::INTERVAL_IDX) begin
        interval_period <= pwdata[15:0];
      end
    end
  end

  // Microsecond tick for the settling and interval counters.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= 5'h00;
      tick     <= 1'b0;
    end else if (ce) begin
      tick     <= (tick_cnt == 5'h00);
      tick_cnt <= (tick_cnt == 5'h00) ? 5'(touch_sar_pkg::TICK_CYC - 5'h01) : 5'(tick_cnt - 5'h01);
    end
  end

  // Sequencer: touch detect, settle, convert, interval wait and recheck.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= touch_sar_pkg::S_IDLE;
      meas       <= touch_sar_pkg::MEAS_Y;
      wait_cnt   <= 16'h0000;
      conv_start <= 1'b0;
    end else if (ce) begin
      conv_start <= 1'b0;
      if (pwr_down) begin
        state <= touch_sar_pkg::S_IDLE;
      end else begin
        unique case (state)
          touch_sar_pkg::S_IDLE: begin
            if (touch && self_run) begin
              state    <= (first_meas == touch_sar_pkg::MEAS_NONE) ? touch_sar_pkg::S_INTERVAL
                                                                   : touch_sar_pkg::S_SETTLE;
              meas     <= touch_sar_pkg::meas_t'(first_meas[1:0]);
              wait_cnt <= (first_meas == touch_sar_pkg::MEAS_NONE) ? interval_period : settle_load;
            end else if (touch) begin
              state <= touch_sar_pkg::S_HOST_WAIT;
            end
          end
          touch_sar_pkg::S_HOST_WAIT: begin
            if (wr_en && idx == touch_sar_pkg::MODE_IDX) begin
              state    <= (host_first == touch_sar_pkg::MEAS_NONE) ? touch_sar_pkg::S_INTERVAL
                                                                   : touch_sar_pkg::S_SETTLE;
              meas     <= touch_sar_pkg::meas_t'(host_first[1:0]);
              wait_cnt <= (host_first == touch_sar_pkg::MEAS_NONE) ? interval_period : settle_load;
            end
          end
          touch_sar_pkg::S_SETTLE: begin
            if (wait_cnt == 16'h0000) begin
              state      <= touch_sar_pkg::S_CONVERT;
              conv_start <= 1'b1;
            end else if (tick) begin
              wait_cnt <= 16'(wait_cnt - 16'h0001);
            end
          end
          touch_sar_pkg::S_CONVERT: begin
            if (conv_done && after_meas == touch_sar_pkg::MEAS_NONE) begin
              state    <= touch_sar_pkg::S_INTERVAL;
              wait_cnt <= interval_period;
            end else if (conv_done) begin
              state    <= touch_sar_pkg::S_SETTLE;
              meas     <= touch_sar_pkg::meas_t'(after_meas[1:0]);
              wait_cnt <= settle_load;
            end
          end
          touch_sar_pkg::S_INTERVAL: begin
            if (wait_cnt == 16'h0000 && touch) begin
              state    <= (first_meas == touch_sar_pkg::MEAS_NONE) ? touch_sar_pkg::S_INTERVAL
                                                                   : touch_sar_pkg::S_SETTLE;
              meas     <= touch_sar_pkg::meas_t'(first_meas[1:0]);
              wait_cnt <= (first_meas == touch_sar_pkg::MEAS_NONE) ? interval_period : settle_load;
            end else if (wait_cnt == 16'h0000) begin
              state <= touch_sar_pkg::S_IDLE;
            end else if (tick) begin
              wait_cnt <= 16'(wait_cnt - 16'h0001);
            end
          end
        endcase
      end
    end
  end

  // Panel drivers and input selector follow the current measurement.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_xp     <= 1'b0;
      drive_xn     <= 1'b0;
      drive_yp     <= 1'b0;
      drive_yn     <= 1'b0;
      ref_diff     <= 1'b0;
      conv_channel <= 2'h0;
    end else if (ce) begin
      if (pwr_down || state == touch_sar_pkg::S_IDLE || state == touch_sar_pkg::S_HOST_WAIT
          || state == touch_sar_pkg::S_INTERVAL) begin
        drive_xp <= 1'b0;
        drive_xn <= 1'b0;
        drive_yp <= 1'b0;
        drive_yn <= 1'b0;
        ref_diff <= 1'b0;
      end else begin
        drive_yp <= (meas != touch_sar_pkg::MEAS_X);
        drive_yn <= (meas == touch_sar_pkg::MEAS_Y);
        drive_xp <= (meas == touch_sar_pkg::MEAS_X);
        drive_xn <= (meas != touch_sar_pkg::MEAS_Y);
        ref_diff <= 1'b1;
      end
      conv_channel <= meas;
    end
  end

  // Converter power and resolution.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_powerdown  <= 1'b1;
      conv_resolution <= touch_sar_pkg::RES_12;
    end else if (ce) begin
      conv_powerdown  <= pwr_down || state == touch_sar_pkg::S_IDLE
                         || state == touch_sar_pkg::S_HOST_WAIT;
      conv_resolution <= conv_power_config[touch_sar_pkg::RES_LSB +: 2];
    end
  end

  // Result store; each register changes only on its own quantity.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) begin
        result[i] <= 12'h000;
      end
    end else if (ce && !pwr_down && state == touch_sar_pkg::S_CONVERT && conv_done) begin
      result[meas] <= masked;
    end
  end

  // Pen and data flags; a set in the same cycle as its clear wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pen_pending <= 1'b0;
      data_avail  <= 1'b0;
    end else if (ce) begin
      if (!pwr_down && state == touch_sar_pkg::S_IDLE && touch && !self_run) begin
        pen_pending <= 1'b1;
      end else if (state == touch_sar_pkg::S_HOST_WAIT && wr_en && idx == touch_sar_pkg::MODE_IDX) begin
        pen_pending <= 1'b0;
      end
      if (!pwr_down && state == touch_sar_pkg::S_CONVERT && conv_done
          && after_meas == touch_sar_pkg::MEAS_NONE) begin
        data_avail <= 1'b1;
      end else if (rd_en && idx == touch_sar_pkg::STATUS_IDX) begin
        data_avail <= 1'b0;
      end
    end
  end

  // Interrupt pin by function code.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_pin_a_n <= 1'b1;
    end else if (ce) begin
      interrupt_pin_a_n <= !((pen_pending && (irq_func == touch_sar_pkg::IRQ_PEN
                                             || irq_func == touch_sar_pkg::IRQ_PEN_DATA))
                            || (data_avail && (irq_func == touch_sar_pkg::IRQ_DATA
                                              || irq_func == touch_sar_pkg::IRQ_PEN_DATA)));
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_idle_touch;
    ce && !pwr_down && state == touch_sar_pkg::S_IDLE && touch;
  endsequence
  sequence s_set_done;
    ce && !pwr_down && state == touch_sar_pkg::S_CONVERT && conv_done;
  endsequence

  property p_power_down;
    ce && pwr_down |=> state == touch_sar_pkg::S_IDLE ##1 !conv_start && conv_powerdown;
  endproperty
  a_power_down: assert property (p_power_down) else $error("power-down did not stop the sequencer");

  property p_host_hold;
    s_idle_touch ##0 !self_run |=> state == touch_sar_pkg::S_HOST_WAIT ##1 !conv_start;
  endproperty
  a_host_hold: assert property (p_host_hold) else $error("host mode converted without a host write");

  property p_self_start;
    s_idle_touch ##0 self_run && first_meas != touch_sar_pkg::MEAS_NONE |=> state == touch_sar_pkg::S_SETTLE;
  endproperty
  a_self_start: assert property (p_self_start) else $error("self mode did not start on touch");

  property p_settle_gap;
    ce && state == touch_sar_pkg::S_SETTLE && wait_cnt != 16'h0000 |=> !conv_start;
  endproperty
  a_settle_gap: assert property (p_settle_gap) else $error("conversion started before settling ended");

  property p_driven_start;
    conv_start |-> ref_diff && (drive_yp || drive_xp) && state == touch_sar_pkg::S_CONVERT;
  endproperty
  a_driven_start: assert property (p_driven_start) else $error("conversion started with panel undriven");

  property p_store_y;
    s_set_done ##0 meas == touch_sar_pkg::MEAS_Y |=> result[0] == $past(masked);
  endproperty
  a_store_y: assert property (p_store_y) else $error("Y result not stored");

  property p_hold_x;
    !(ce && !pwr_down && state == touch_sar_pkg::S_CONVERT && conv_done && meas == touch_sar_pkg::MEAS_X)
      |=> $stable(result[1]);
  endproperty
  a_hold_x: assert property (p_hold_x) else $error("X result changed without an X conversion");

  property p_untouched_stop;
    ce && !pwr_down && state == touch_sar_pkg::S_INTERVAL && wait_cnt == 16'h0000 && !touch
      |=> state == touch_sar_pkg::S_IDLE;
  endproperty
  a_untouched_stop: assert property (p_untouched_stop) else $error("sequence kept running without touch");

  property p_pen_irq;
    ce && pen_pending && irq_func == touch_sar_pkg::IRQ_PEN |=> !interrupt_pin_a_n;
  endproperty
  a_pen_irq: assert property (p_pen_irq) else $error("pen interrupt not raised");

endmodule

// [tb/adc_panel_model.sv]
/*
  Far-side model of the shared converter behind the panel switches: each start
  pulse is answered after a set latency with a value made from channel and salt.
  Assumes a one-cycle start pulse synchronous to pclk and a latency of one or more.
*/
`timescale 1ns/100ps
module adc_panel_model (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Converter control.
  input  wire logic        conv_start,
  input  wire logic [1:0]  conv_channel,
  // Test controls.
  input  wire logic [3:0]  lat,
  input  wire logic [11:0] salt,
  // Converter answer.
  output logic             conv_done,
  output logic      [11:0] conv_data
);
  logic [3:0] cnt;
  logic [1:0] ch;

  // One converter serves every source; data toggles so it is never stale.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt       <= 4'h0;
      ch        <= 2'h0;
      conv_done <= 1'b0;
      conv_data <= 12'h000;
    end else begin
      conv_done <= 1'b0;
      conv_data <= ~conv_data;
      if (conv_start) begin
        cnt <= lat;
        ch  <= conv_channel;
      end else if (cnt == 4'h1) begin
        cnt       <= 4'h0;
        conv_done <= 1'b1;
        conv_data <= salt ^ {10'h000, ch};
      end else if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule

// [tb/touch_panel_sar_sequencer_tb.sv]
/*
  Self-checking bench: APB master, touch stimulus and converter model.
  Assumes the hand-over timing: pready one cycle after setup, 1 us ticks.
*/
`timescale 1ns/100ps
module touch_panel_sar_sequencer_tb;
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, touch, err, low;
  logic        drive_xp, drive_xn, drive_yp, drive_yn, ref_diff, conv_start, conv_powerdown;
  logic        conv_done, irq_n;
  logic [1:0]  conv_channel, conv_resolution;
  logic [11:0] paddr, conv_data, salt, s1;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  lat;
  int          error_cnt, n_tests, n, n2, nx;

  touch_panel_sar_sequencer i_touch_panel_sar_sequencer (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .touch(touch), .drive_xp(drive_xp), .drive_xn(drive_xn),
    .drive_yp(drive_yp), .drive_yn(drive_yn), .ref_diff(ref_diff), .conv_channel(conv_channel),
    .conv_resolution(conv_resolution), .conv_start(conv_start), .conv_powerdown(conv_powerdown),
    .conv_done(conv_done), .conv_data(conv_data), .interrupt_pin_a_n(irq_n));
  adc_panel_model i_adc_panel_model (.pclk(pclk), .presetn(presetn), .conv_start(conv_start),
    .conv_channel(conv_channel), .lat(lat), .salt(salt), .conv_done(conv_done), .conv_data(conv_data));

  // Clock of 50 ns period.
  always #25 pclk = ~pclk;

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer; holds the request until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {2'h0, idx, 2'h0};
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (i == 16) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask

  // Waits for a conversion start; n counts cycles waited.
  task automatic wait_start(input int lim);
    for (n = 0; n < lim; n++) begin
      @(posedge pclk);
      #1;
      if (conv_start === 1'b1) return;
    end
    error_cnt++;
    tally_and_finish();
  endtask

  // Counts starts, X starts and low interrupt over a span.
  task automatic watch(input int cyc);
    n2 = 0;
    nx = 0;
    low = 1'b0;
    repeat (cyc) begin
      @(posedge pclk);
      #1;
      if (conv_start === 1'b1) n2++;
      if (conv_start === 1'b1 && conv_channel === 2'h1) nx++;
      if (irq_n === 1'b0) low = 1'b1;
    end
  endtask

  // Expected switch pattern {xp,xn,yp,yn} per measurement.
  function automatic logic [3:0] drv(input int k);
    return k == 0 ? 4'h3 : k == 1 ? 4'hc : 4'h6;
  endfunction

  // Main sequence.
  initial begin
    {pclk, presetn, psel, penable, pwrite, touch, err, low} = 8'h00;
    ce = 1'b1;
    paddr = 12'h000;
    pwdata = 32'h0;
    error_cnt = 0;
    n_tests = 0;
    void'($urandom(16048));
    salt = 12'($urandom);
    lat = 4'($urandom_range(3, 8));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    chk("powerdown at reset", conv_powerdown, 1);
    apb(0, touch_sar_pkg::MODE_IDX, 0);
    chk("mode reset", rd, touch_sar_pkg::MODE_RST);
    apb(0, 8'h01, 0);
    chk("unmapped error", err, 1);
    for (int r = 0; r < 4; r++) begin
      apb(1, touch_sar_pkg::CONV_POWER_IDX, r << 5);
      apb(0, touch_sar_pkg::CONV_POWER_IDX, 0);
      chk("config readback", rd, r << 5);
      chk("resolution", conv_resolution, r);
    end
    $display("end of register test");
    apb(1, touch_sar_pkg::CONV_POWER_IDX, 0);
    apb(1, touch_sar_pkg::STAB_IDX, 3);
    apb(1, touch_sar_pkg::INTERVAL_IDX, 2);
    apb(1, touch_sar_pkg::MODE_IDX, 8'hbc);
    @(posedge pclk);
    touch <= 1'b1;
    wait_start(200);
    chk("settle cycles", n >= 60 && n <= 84, 1);
    for (int k = 0; k < 4; k++) begin
      if (k > 0) wait_start(200);
      chk("channel order", conv_channel, k);
      chk("drives", {drive_xp, drive_xn, drive_yp, drive_yn, ref_diff}, {drv(k), 1'b1});
    end
    wait_start(400);
    chk("repeat set", conv_channel, 0);
    s1 = salt;
    @(posedge pclk);
    touch <= 1'b0;
    salt <= 12'($urandom);
    watch(400);
    chk("x skipped", nx, 0);
    for (int k = 0; k < 4; k++) begin
      apb(0, 8'(touch_sar_pkg::RESULT_IDX + 2 * k), 0);
      chk("result high", rd, ((k == 1 ? s1 : salt) ^ k) >> 8);
      apb(0, 8'(touch_sar_pkg::RESULT_IDX + 2 * k + 1), 0);
      chk("result low", rd, ((k == 1 ? s1 : salt) ^ k) & 12'h0ff);
    end
    $display("end of self-run test");
    apb(1, touch_sar_pkg::MODE_IDX, 8'h84);
    @(posedge pclk);
    touch <= 1'b1;
    wait_start(200);
    apb(1, touch_sar_pkg::CONV_POWER_IDX, 8'h80);
    repeat (3) @(posedge pclk);
    #1;
    chk("forced off", {drive_xp, drive_xn, drive_yp, drive_yn, conv_powerdown}, 5'h01);
    @(posedge pclk);
    touch <= 1'b0;
    apb(1, touch_sar_pkg::CONV_POWER_IDX, 0);
    $display("end of power-down test");
    apb(1, touch_sar_pkg::MODE_IDX, 8'h00);
    @(posedge pclk);
    touch <= 1'b1;
    watch(10);
    chk("pen interrupt", low, 1);
    watch(100);
    chk("held off", n2, 0);
    apb(1, touch_sar_pkg::MODE_IDX, 8'h04);
    wait_start(200);
    chk("host start", conv_channel, 0);
    @(posedge pclk);
    touch <= 1'b0;
    watch(600);
    chk("stopped", n2, 0);
    apb(0, touch_sar_pkg::STATUS_IDX, 0);
    apb(1, touch_sar_pkg::MODE_IDX, 8'h02);
    #1;
    chk("interrupt released", irq_n, 1);
    @(posedge pclk);
    touch <= 1'b1;
    watch(100);
    chk("interrupt again", low, 1);
    chk("waits again", n2, 0);
    $display("end of host-run test");
    tally_and_finish();
  end
endmodule
